// ### design/pcg_peripheral_clock_gating.sv
/*
 * Peripheral clock gating and sleep-time power control.
 * Holds the power reduction register, scan port disable, input disable
 * registers and sleep control, and produces per-peripheral clock enables,
 * gated clocks and analog/oscillator keep-alive levels.
 * Assumes fuses, wake and peripheral status come from same-clock logic,
 * so none of the inputs pass a synchroniser here.
 */
// Notes on behaviour
// - One control bit per peripheral stops that peripheral's clock.
// - Stopped peripheral is frozen; its registers are unreachable by software.
// - Clearing the bit restarts the clock with state unchanged.
// - Gating bits matter in active and idle; other sleeps stop clocks anyway.
// - Upper three register bits are read-only and read as zero.
// - Bit 4 stops the LCD controller; software disables it first.
// - Bit 3 stops the wide timer, which later resumes unchanged.
// - Bit 2 stops the serial peripheral; software re-initialises afterwards.
// - Bit 1 stops the async serial unit; software re-initialises afterwards.
// - Bit 0 stops the converter; software disables it first.
// - Converter off blocks comparator use of the converter input mux.
// - Enabled converter stays on in sleep; re-enable forces an extended conversion.
// - Comparator off in deep sleeps unless it uses the reference; then both stay on.
// - Reference on only when brown-out, comparator or converter need it.
// - Fuse-enabled brown-out detector stays on in every sleep mode.
// - Enabled watchdog keeps running in every sleep mode.
// - Input buffers off when I/O and converter clocks stop, except wake pins.
// - Input disable registers turn off matching analog pin input buffers.
// - Debug fuse keeps the main clock running in power-down and power-save while the scan port is on.
// - Disable bit or unprogrammed enable fuse turns off the scan port.
// - Scan output undriven when enabled but not shifting.
// - Sleep codes: idle 000, noise 001, down 010, save 011, standby 110.
// - Power-down halts all generated clocks except the main clock kept by the debug fuse.
module pcg_peripheral_clock_gating #(
   parameter int PIN_COUNT = 8
) (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic                       ce,
   input  wire logic [7:0]                 addr,
   input  wire logic [7:0]                 wdata,
   input  wire logic                       wr,
   input  wire logic                       rd,
   output logic      [7:0]                 rdata,
   input  wire logic                       sleep_req,
   input  wire logic                       wake,
   input  wire logic                       onchip_debug_fuse,
   input  wire logic                       scan_port_enable_fuse,
   input  wire logic [1:0]                 brownout_level_fuses,
   input  wire logic                       watchdog_enable,
   input  wire logic                       converter_enable,
   input  wire logic                       tap_shifting,
   input  wire logic                       tap_tdo,
   input  wire logic [PIN_COUNT-1:0]       wake_pin_mask,
   output logic      [pcg_pkg::PCG_NUM_GATED-1:0] periph_clk_en,
   output logic      [pcg_pkg::PCG_NUM_GATED-1:0] periph_clk,
   output logic      [pcg_pkg::PCG_NUM_GATED-1:0] periph_reg_access,
   output logic                            cpu_clk_run,
   output logic                            io_clk_run,
   output logic                            conv_clk_run,
   output logic                            async_clk_run,
   output logic                            main_osc_run,
   output logic                            converter_on,
   output logic                            converter_extended,
   output logic                            comparator_mux_allow,
   output logic                            comparator_on,
   output logic                            vref_on,
   output logic                            brownout_on,
   output logic                            watchdog_run,
   output logic      [PIN_COUNT-1:0]       input_buf_en,
   output logic                            scan_port_on,
   output logic                            scan_tdo_o,
   output logic                            scan_tdo_oe
);
   initial begin
      if (PIN_COUNT < 1 || PIN_COUNT > 16) begin
         $error("PIN_COUNT must lie between 1 and 16");
      end
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   pcg_pkg::pcg_state_t st;
   pcg_pkg::pcg_state_t next_st;
   logic [2:0]          mode;
   logic                asleep;
   logic                deep;
   logic                io_stop;
   logic                conv_stop;
   logic                bod_fused;
   logic                cmp_active;
   logic [4:0]          gate_req;
   logic [4:0]          gate_lat;

   assign mode      = st.sleep_ctl[2:0];
   assign asleep    = (st.phase == pcg_pkg::PCG_SLEEPING);
   // Modes beyond idle and noise reduction stop the I/O and converter clocks
   assign deep      = asleep && (mode != pcg_pkg::PCG_SM_IDLE) && (mode != pcg_pkg::PCG_SM_NOISE_RED);
   assign io_stop   = asleep && (mode != pcg_pkg::PCG_SM_IDLE);
   assign conv_stop = deep;
   assign bod_fused = (brownout_level_fuses != 2'h3);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.rdata = pcg_pkg::PCG_READ_IDLE;
      if (wr) begin
         case (addr[3:0])
            pcg_pkg::PCG_ADDR_POWER_REDUCTION:
               next_st.peripheral_power_reduction = wdata & pcg_pkg::PCG_PRR_WMASK;
            pcg_pkg::PCG_ADDR_SYSTEM_CONTROL: next_st.sysctl = wdata;
            pcg_pkg::PCG_ADDR_INPUT_DIS_LOW:  next_st.didr_low = wdata;
            pcg_pkg::PCG_ADDR_INPUT_DIS_HIGH: next_st.didr_high = wdata;
            pcg_pkg::PCG_ADDR_SLEEP_CONTROL:  next_st.sleep_ctl = wdata;
            default: ;
         endcase
      end
      if (rd) begin
         case (addr[3:0])
            pcg_pkg::PCG_ADDR_POWER_REDUCTION: next_st.rdata = st.peripheral_power_reduction & pcg_pkg::PCG_PRR_WMASK;
            pcg_pkg::PCG_ADDR_SYSTEM_CONTROL:  next_st.rdata = st.sysctl;
            pcg_pkg::PCG_ADDR_INPUT_DIS_LOW:   next_st.rdata = st.didr_low;
            pcg_pkg::PCG_ADDR_INPUT_DIS_HIGH:  next_st.rdata = st.didr_high;
            pcg_pkg::PCG_ADDR_SLEEP_CONTROL:   next_st.rdata = st.sleep_ctl;
            pcg_pkg::PCG_ADDR_STATUS:
               next_st.rdata = {4'h0, st.conv_extended, vref_on, scan_port_on, asleep};
            default: next_st.rdata = pcg_pkg::PCG_READ_IDLE;
         endcase
      end
      // Converter power history: a fresh switch-on asks for a long conversion
      next_st.conv_was_on = converter_on;
      if (converter_on && !st.conv_was_on) begin
         next_st.conv_extended = 1'b1;
      end else if (!converter_on) begin
         next_st.conv_extended = st.conv_extended;
      end
      case (st.phase)
         pcg_pkg::PCG_RUN:
            if (sleep_req && st.sleep_ctl[pcg_pkg::PCG_BIT_SLEEP_ACT]) begin
               next_st.phase = pcg_pkg::PCG_SLEEP_ENTRY;
            end
         pcg_pkg::PCG_SLEEP_ENTRY: next_st.phase = pcg_pkg::PCG_SLEEPING;
         pcg_pkg::PCG_SLEEPING:
            if (wake) begin
               next_st.phase = pcg_pkg::PCG_RUN;
            end
         default: next_st.phase = pcg_pkg::PCG_RUN;
      endcase
      if (rst) begin
         next_st.peripheral_power_reduction           = pcg_pkg::PCG_PRR_RESET;
         next_st.sysctl        = pcg_pkg::PCG_SYSCTL_RESET;
         next_st.didr_low      = pcg_pkg::PCG_DIDR_RESET;
         next_st.didr_high     = pcg_pkg::PCG_DIDR_RESET;
         next_st.sleep_ctl     = pcg_pkg::PCG_SLEEP_RESET;
         next_st.rdata         = pcg_pkg::PCG_READ_IDLE;
         next_st.conv_was_on   = 1'b0;
         next_st.conv_extended = 1'b0;
         next_st.phase         = pcg_pkg::PCG_RUN;
      end
   end

   always_ff @(posedge clk) begin
      if (ce || rst) begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Peripheral clock gates
   // ----------------------------------------------------------------
   // Stopping the clock freezes the peripheral; clearing restores it as it was
   assign gate_req = ~st.peripheral_power_reduction[4:0] & {5{~io_stop}};
   // Latch opens only while clk is low so the gated clock never gets a sliver
   always_latch begin
      if (!clk) begin
         gate_lat = gate_req;
      end
   end
   assign periph_clk_en     = gate_req;
   assign periph_clk        = gate_lat & {5{clk}};
   assign periph_reg_access = ~st.peripheral_power_reduction[4:0];

   // ----------------------------------------------------------------
   // Sleep domain clocks and oscillators
   // ----------------------------------------------------------------
   assign cpu_clk_run   = !asleep;
   assign io_clk_run    = !io_stop;
   assign conv_clk_run  = !conv_stop;
   assign async_clk_run = !(asleep && (mode == pcg_pkg::PCG_SM_POWER_DN || mode == pcg_pkg::PCG_SM_STANDBY));
   // Debug fuse costs sleep current but keeps the debugger attached
   assign main_osc_run  = !deep || mode == pcg_pkg::PCG_SM_STANDBY
                          || (onchip_debug_fuse && scan_port_on);

   // ----------------------------------------------------------------
   // Analog blocks
   // ----------------------------------------------------------------
   assign converter_on         = converter_enable && !st.peripheral_power_reduction[pcg_pkg::PCG_BIT_CONVERTER];
   assign converter_extended   = st.conv_extended;
   assign comparator_mux_allow = !st.peripheral_power_reduction[pcg_pkg::PCG_BIT_CONVERTER];
   assign cmp_active           = !st.sleep_ctl[pcg_pkg::PCG_BIT_CMP_DIS];
   assign comparator_on        = cmp_active && (!deep || st.sleep_ctl[pcg_pkg::PCG_BIT_CMP_VREF]);
   assign vref_on              = bod_fused || converter_on
                                 || (comparator_on && st.sleep_ctl[pcg_pkg::PCG_BIT_CMP_VREF]);
   assign brownout_on          = bod_fused;
   assign watchdog_run         = watchdog_enable;

   // ----------------------------------------------------------------
   // Input buffers
   // ----------------------------------------------------------------
   logic [15:0] didr_all;
   assign didr_all = {st.didr_high, st.didr_low};
   assign input_buf_en = ~didr_all[PIN_COUNT-1:0]
                         & ((io_stop && conv_stop) ? wake_pin_mask : {PIN_COUNT{1'b1}});

   // ----------------------------------------------------------------
   // Scan port
   // ----------------------------------------------------------------
   assign scan_port_on = scan_port_enable_fuse && !st.sysctl[pcg_pkg::PCG_BIT_SCAN_DIS];
   assign scan_tdo_o   = tap_tdo;
   assign scan_tdo_oe  = scan_port_on && tap_shifting;
   assign rdata        = st.rdata;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_write_prr;
      ce && wr && addr[3:0] == pcg_pkg::PCG_ADDR_POWER_REDUCTION;
   endsequence

   a_prr_upper_zero: assert property (s_write_prr |=> st.peripheral_power_reduction[7:5] == 3'h0)
      else $error("reserved bits stored");
   a_gate_follows_bit: assert property (s_write_prr ##1 !io_stop |-> periph_clk_en == ~st.peripheral_power_reduction[4:0])
      else $error("clock enable does not follow register");
   a_read_prr_back: assert property (s_write_prr ##1 (ce && rd && addr[3:0] == 4'h0 && !wr)
                                     |=> rdata == ($past(wdata, 2) & 8'h1F))
      else $error("register readback wrong");
   a_deep_stops_clocks: assert property (deep |-> periph_clk_en == 5'h0 && !conv_clk_run)
      else $error("clock runs in deep sleep");
   a_conv_mux_block: assert property (st.peripheral_power_reduction[0] |-> !comparator_mux_allow && !converter_on)
      else $error("converter mux reachable while stopped");
   a_scan_tdo_float: assert property (!tap_shifting |-> !scan_tdo_oe)
      else $error("scan output driven while idle");
   a_scan_disable: assert property ($rose(st.sysctl[7]) |-> !scan_port_on)
      else $error("scan port still on");
   a_debug_osc: assert property (deep && onchip_debug_fuse && scan_port_on |-> main_osc_run)
      else $error("main oscillator stopped with debug");
   a_bod_sleep: assert property (bod_fused |-> brownout_on && vref_on)
      else $error("brown-out detector lost");
   a_conv_extended: assert property ($rose(converter_on) && ce |=> converter_extended)
      else $error("no extended conversion");
   // Outside reset, without the enable nothing may move, not even the read data register
   a_ce_freeze_state: assert property (!ce |=> st == $past(st))
      else $error("state moved while clock enable low");
   a_idle_gates_kept: assert property (asleep && mode == pcg_pkg::PCG_SM_IDLE
                                       |-> periph_clk_en == ~st.peripheral_power_reduction[4:0])
      else $error("idle sleep overrides gating bits");
endmodule

// ### design/pcg_pkg.sv
/*
 * Package for the peripheral clock gating block: register map, field
 * positions, reset values, sleep mode codes and the packed carriers.
 * Assumes a single 10 MHz system clock and a plain strobe register port.
 */
package pcg_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] PCG_ADDR_POWER_REDUCTION = 4'h0;
   localparam logic [3:0] PCG_ADDR_SYSTEM_CONTROL  = 4'h1;
   localparam logic [3:0] PCG_ADDR_INPUT_DIS_LOW   = 4'h2;
   localparam logic [3:0] PCG_ADDR_INPUT_DIS_HIGH  = 4'h3;
   localparam logic [3:0] PCG_ADDR_SLEEP_CONTROL   = 4'h4;
   localparam logic [3:0] PCG_ADDR_STATUS          = 4'h5;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int         PCG_BIT_CONVERTER = 0;
   localparam int         PCG_BIT_ASYNC_SER = 1;
   localparam int         PCG_BIT_SER_PERIPH = 2;
   localparam int         PCG_BIT_WIDE_TIMER = 3;
   localparam int         PCG_BIT_LCD       = 4;
   localparam int         PCG_NUM_GATED     = 5;
   localparam logic [7:0] PCG_PRR_WMASK     = 8'h1F;
   localparam logic [7:0] PCG_PRR_RESET     = 8'h00;
   localparam int         PCG_BIT_SCAN_DIS  = 7;
   localparam logic [7:0] PCG_SYSCTL_RESET  = 8'h00;
   localparam logic [7:0] PCG_DIDR_RESET    = 8'h00;
   localparam int         PCG_BIT_SLEEP_ACT = 3;
   localparam int         PCG_BIT_CMP_DIS   = 4;
   localparam int         PCG_BIT_CMP_VREF  = 5;
   localparam logic [7:0] PCG_SLEEP_RESET   = 8'h00;
   localparam logic [7:0] PCG_READ_IDLE     = 8'h00;

   // ----------------------------------------------------------------
   // Sleep mode codes
   // ----------------------------------------------------------------
   localparam logic [2:0] PCG_SM_IDLE      = 3'h0;
   localparam logic [2:0] PCG_SM_NOISE_RED = 3'h1;
   localparam logic [2:0] PCG_SM_POWER_DN  = 3'h2;
   localparam logic [2:0] PCG_SM_POWER_SV  = 3'h3;
   localparam logic [2:0] PCG_SM_STANDBY   = 3'h6;

   typedef enum logic [1:0] {PCG_RUN, PCG_SLEEP_ENTRY, PCG_SLEEPING} pcg_phase_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pcg_bus_req_t;

   typedef struct packed {
      logic [7:0] peripheral_power_reduction;
      logic [7:0] sysctl;
      logic [7:0] didr_low;
      logic [7:0] didr_high;
      logic [7:0] sleep_ctl;
      logic [7:0] rdata;
      logic       conv_was_on;
      logic       conv_extended;
      pcg_phase_t phase;
   } pcg_state_t;
endpackage

// ### tb/pcg_periph_model.sv
/*
 * Behavioural stand-in for one gated peripheral: a free counter on its gated clock.
 * Assumes the gated clock comes from the clock gating block and reset is synchronous.
 */
module pcg_periph_model (
   input  wire logic       gclk,
   input  wire logic       rst,
   output logic      [7:0] count
);
   timeunit 1ns;
   timeprecision 1ns;

   // Counts only on gated edges, so a stopped clock freezes the value in place
   always_ff @(posedge gclk) begin
      if (rst) begin
         count <= 8'h00;
      end else begin
         count <= count + 8'h01;
      end
   end
endmodule

// ### tb/pcg_peripheral_clock_gating_tb.sv
/*
 * Self-checking bench for the peripheral clock gating block.
 * Assumes a 10 MHz clock, synchronous active-high reset and the plain strobe register port.
 */
module pcg_peripheral_clock_gating_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [7:0] wr_val; logic [7:0] rd_val;} pcg_row_t;
   typedef struct packed {logic [2:0] mode; logic io; logic conv; logic osc; logic asy; logic [7:0] buf_en;} pcg_mode_t;
   logic       clk, rst, ce, wr, rd, sleep_req, wake, dbg_fuse, scan_fuse, wdog, conv_en, tap_sh, tap_tdo;
   logic [7:0] addr, wdata, rdata, pin_mask, input_buf_en, cnt, cnt_hold;
   logic [1:0] bod_fuses;
   logic [4:0] clk_en, gclk, reg_acc;
   logic       cpu_run, io_run, conv_run, osc_run, mux_ok, vref, bod_on, wdog_run, scan_on, tdo, tdo_oe;
   logic       asy_run, conv_on, conv_ext, cmp_on;
   int         error_cnt, n_compared, cycles;
   pcg_row_t   rows [8] = '{'{8'hFF, 8'h1F}, '{8'h00, 8'h00}, '{8'h10, 8'h10}, '{8'h08, 8'h08},
                            '{8'h04, 8'h04}, '{8'h02, 8'h02}, '{8'h01, 8'h01}, '{8'hE0, 8'h00}};
   pcg_mode_t  modes [5] = '{'{3'h0, 1'b1, 1'b1, 1'b1, 1'b1, 8'hFF}, '{3'h1, 1'b0, 1'b1, 1'b1, 1'b1, 8'hFF},
                            '{3'h2, 1'b0, 1'b0, 1'b0, 1'b0, 8'h03}, '{3'h3, 1'b0, 1'b0, 1'b0, 1'b1, 8'h03},
                            '{3'h6, 1'b0, 1'b0, 1'b1, 1'b0, 8'h03}};

   pcg_peripheral_clock_gating #(.PIN_COUNT(8)) dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .sleep_req(sleep_req), .wake(wake), .onchip_debug_fuse(dbg_fuse),
      .scan_port_enable_fuse(scan_fuse), .brownout_level_fuses(bod_fuses), .watchdog_enable(wdog),
      .converter_enable(conv_en), .tap_shifting(tap_sh), .tap_tdo(tap_tdo), .wake_pin_mask(pin_mask),
      .periph_clk_en(clk_en), .periph_clk(gclk), .periph_reg_access(reg_acc), .cpu_clk_run(cpu_run),
      .io_clk_run(io_run), .conv_clk_run(conv_run), .async_clk_run(asy_run), .main_osc_run(osc_run),
      .converter_on(conv_on), .converter_extended(conv_ext), .comparator_mux_allow(mux_ok), .comparator_on(cmp_on),
      .vref_on(vref), .brownout_on(bod_on), .watchdog_run(wdog_run), .input_buf_en(input_buf_en),
      .scan_port_on(scan_on), .scan_tdo_o(tdo), .scan_tdo_oe(tdo_oe));
   pcg_periph_model u_timer (.gclk(gclk[3]), .rst(rst), .count(cnt));

   // ----------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Whole run is well under 2000 cycles; the ceiling leaves margin for slow paths
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         error_cnt++;
         wrap_up();
      end
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
      @(posedge clk) wr <= 1'b0;
      @(negedge clk);
   endtask
   // Read data stand only in the cycle after the strobe, so sample there
   task automatic rd_reg(input string name, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk) begin rd <= 1'b1; addr <= a; end
      @(posedge clk) rd <= 1'b0;
      @(negedge clk) chk(name, exp, rdata);
   endtask
   task automatic sleep_in(input logic [2:0] mode);
      wr_reg(pcg_pkg::PCG_ADDR_SLEEP_CONTROL, {5'h01, mode});
      @(posedge clk) sleep_req <= 1'b1;
      @(posedge clk) sleep_req <= 1'b0;
      @(posedge clk);
      @(negedge clk);
   endtask
   task automatic wake_up();
      @(posedge clk) wake <= 1'b1;
      @(posedge clk) wake <= 1'b0;
      @(negedge clk);
   endtask
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {ce, rst} = 2'b11;
      {wr, rd, sleep_req, wake, dbg_fuse, tap_sh, tap_tdo, wdog, conv_en} = '0;
      {addr, wdata, cycles, error_cnt, n_compared} = '0;
      scan_fuse = 1'b1;
      bod_fuses = 2'b11;
      pin_mask = 8'h03;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk) chk("clk_en after reset", 8'h1F, {3'h0, clk_en});
      rd_reg("prr reset", pcg_pkg::PCG_ADDR_POWER_REDUCTION, 8'h00);
      rd_reg("unmapped", 8'h0F, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr_reg(pcg_pkg::PCG_ADDR_POWER_REDUCTION, rows[i].wr_val);
         chk("clk_en", {3'h0, ~rows[i].rd_val[4:0]}, {3'h0, clk_en});
         chk("reg_access", {3'h0, ~rows[i].rd_val[4:0]}, {3'h0, reg_acc});
         rd_reg("prr", pcg_pkg::PCG_ADDR_POWER_REDUCTION, rows[i].rd_val);
      end
      // Timer frozen while gated, then resumes from where it stopped
      wr_reg(pcg_pkg::PCG_ADDR_POWER_REDUCTION, 8'h08);
      cnt_hold = cnt;
      repeat (10) @(posedge clk);
      @(negedge clk) chk("timer frozen", cnt_hold, cnt);
      wr_reg(pcg_pkg::PCG_ADDR_POWER_REDUCTION, 8'h01);
      chk("mux blocked", 8'h00, {7'h0, mux_ok});
      // Gate latch reopens at the falling edge, so the first counted edge is one cycle on
      @(posedge clk);
      @(negedge clk) chk("timer resumed", cnt_hold + 8'h01, cnt);
      wr_reg(pcg_pkg::PCG_ADDR_POWER_REDUCTION, 8'h00);
      chk("mux allowed", 8'h01, {7'h0, mux_ok});
      // Converter switched on asks for a long conversion; disabled before its clock stops
      @(posedge clk) conv_en <= 1'b1;
      @(negedge clk) chk("conv on", 8'h01, {7'h0, conv_on});
      @(posedge clk);
      @(negedge clk) chk("conv extended", 8'h01, {7'h0, conv_ext});
      @(posedge clk) conv_en <= 1'b0;
      wr_reg(pcg_pkg::PCG_ADDR_POWER_REDUCTION, 8'h01);
      chk("conv stopped", 8'h00, {7'h0, conv_on});
      wr_reg(pcg_pkg::PCG_ADDR_POWER_REDUCTION, 8'h00);
      // Reference and keep-alives: comparator disabled, then brown-out needs it
      wr_reg(pcg_pkg::PCG_ADDR_SLEEP_CONTROL, 8'h10);
      chk("vref off", 8'h00, {7'h0, vref});
      @(posedge clk) begin bod_fuses <= 2'b10; wdog <= 1'b1; end
      @(negedge clk) chk("vref bod", 8'h01, {7'h0, vref});
      wr_reg(pcg_pkg::PCG_ADDR_INPUT_DIS_LOW, 8'h0F);
      chk("didr buffers", 8'hF0, input_buf_en);
      wr_reg(pcg_pkg::PCG_ADDR_INPUT_DIS_LOW, 8'h00);
      for (int m = 0; m < 5; m++) begin
         sleep_in(modes[m].mode);
         chk("cpu clk", 8'h00, {7'h0, cpu_run});
         chk("io clk", {7'h0, modes[m].io}, {7'h0, io_run});
         chk("conv clk", {7'h0, modes[m].conv}, {7'h0, conv_run});
         chk("main osc", {7'h0, modes[m].osc}, {7'h0, osc_run});
         chk("async clk", {7'h0, modes[m].asy}, {7'h0, asy_run});
         chk("comparator", {7'h0, modes[m].conv}, {7'h0, cmp_on});
         chk("buffers", modes[m].buf_en, input_buf_en);
         chk("keep alive", 8'h03, {6'h0, bod_on, wdog_run});
         chk("gates", (m == 0) ? 8'h1F : 8'h00, {3'h0, clk_en});
         wake_up();
         chk("cpu woke", 8'h01, {7'h0, cpu_run});
      end
      @(posedge clk) dbg_fuse <= 1'b1;
      sleep_in(pcg_pkg::PCG_SM_POWER_DN);
      chk("osc debug", 8'h01, {7'h0, osc_run});
      wake_up();
      // Scan port: idle output floats, shifting drives, disable bit and fuse turn it off
      chk("tdo float", 8'h00, {7'h0, tdo_oe});
      @(posedge clk) begin tap_sh <= 1'b1; tap_tdo <= 1'b1; end
      @(negedge clk) chk("tdo drive", 8'h03, {6'h0, tdo_oe, tdo});
      wr_reg(pcg_pkg::PCG_ADDR_SYSTEM_CONTROL, 8'h80);
      chk("scan disabled", 8'h00, {7'h0, scan_on});
      wr_reg(pcg_pkg::PCG_ADDR_SYSTEM_CONTROL, 8'h00);
      chk("scan enabled", 8'h01, {7'h0, scan_on});
      @(posedge clk) scan_fuse <= 1'b0;
      @(negedge clk) chk("scan fuse off", 8'h00, {7'h0, scan_on});
      wr_reg(pcg_pkg::PCG_ADDR_POWER_REDUCTION, 8'h1F);
      @(posedge clk) rst <= 1'b1;
      @(posedge clk) rst <= 1'b0;
      @(negedge clk) chk("clk_en second reset", 8'h1F, {3'h0, clk_en});
      wrap_up();
   end
endmodule
